/* dv/ccp_chk.sv */
// Pin assertions of the configuration pin controller
module ccp_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched pins
   input wire logic chain_enable_in_n_i,
   input wire logic chain_enable_out_n_o,
   input wire logic chain_enable_out_oe_o,
   input wire logic [1:0] mode_sel_i,
   input wire logic dual_purpose_user_i,
   input wire logic config_clock_o,
   input wire logic config_clock_oe_o,
   input wire logic flash_select_n_o,
   input wire logic load_complete_i,
   input wire logic load_complete_o,
   input wire logic load_complete_oe_o,
   input wire logic user_ceo_out_i,
   input wire logic user_ceo_oe_i,
   input wire logic configured_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_chain_gate: assert property (
      $rose(configured_o) |-> !$past(chain_enable_in_n_i, 3))
      else $error("configured without enable");
   a_ceo_early: assert property (!configured_o |->
      !chain_enable_out_oe_o) else $error("chain out driven early");
   a_ceo_user: assert property (
      configured_o && !dual_purpose_user_i |->
      chain_enable_out_oe_o && !chain_enable_out_n_o)
      else $error("chain out not low");
   a_user_io: assert property (
      configured_o && dual_purpose_user_i && $stable(user_ceo_out_i)
      && $stable(user_ceo_oe_i) |-> chain_enable_out_n_o == user_ceo_out_i
      && chain_enable_out_oe_o == user_ceo_oe_i)
      else $error("user drive ignored");
   a_cs_fetch: assert property (!flash_select_n_o |->
      mode_sel_i == ccp_pkg::MODE_SELF_FETCH) else $error("stray select");
   a_clk_owner: assert property (config_clock_oe_o |->
      mode_sel_i == ccp_pkg::MODE_SELF_FETCH) else $error("clock driven");
   a_clk_park: assert property (configured_o |->
      config_clock_o == ccp_pkg::CLOCK_PARK_LEVEL) else $error("no park");
   a_user_locked: assert property (configured_o |=> configured_o)
      else $error("left user mode");
   a_done_low: assert property (load_complete_oe_o |->
      !load_complete_o && !configured_o) else $error("load complete");
   a_done_wait: assert property ($rose(configured_o) |->
      $past(load_complete_i)) else $error("user before release");
   c_serial: cover property ($rose(configured_o) && mode_sel_i == 2'h0);
   c_byte: cover property ($rose(configured_o) && mode_sel_i == 2'h1);
   c_fetch: cover property ($rose(configured_o) && mode_sel_i == 2'h2);
endmodule // ccp_chk

/* dv/ccp_mem_model.sv */
// Serial configuration memory answering the self-fetch read
module ccp_mem_model (
   // Memory pins
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic cmd_i,
   output logic dq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] cmd_q = 32'h0000_0000;
   logic [7:0] b;
   int rise = 0;
   int n;
   initial dq_o = 1'b1;
   always @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         rise <= 0;
      end else begin
         if (rise < 32) cmd_q <= {cmd_q[30:0], cmd_i};
         rise <= rise + 1;
      end
   end
   // Data leaves on the fall so it is settled at the next rise
   always @(negedge sck_i or posedge cs_n_i) begin
      n = rise - 32;
      b = 8'(n / 8 * 3 + 1);
      if (cs_n_i || n < 0) dq_o <= 1'b1;
      else dq_o <= b[7 - n % 8];
   end
endmodule // ccp_mem_model

/* dv/tb_top.sv */
// Self-checking bench of the configuration pin controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hclk = 1'b0;
   logic chain_enable_in = 1'b1;
   logic tb_bit = 1'b1;
   logic [7:0] tb_byte = 8'h00;
   logic [1:0] mode = 2'h0;
   logic dual = 1'b0;
   logic u_out = 1'b1;
   logic ready = 1'b1;
   logic stall = 1'b0;
   logic ceo_o, ceo_oe, cck_o, cck_oe, cmd, cs_n, hrdy, lc_o, lc_oe;
   logic lvalid, cfgd, mem_bit, ceo_in;
   logic [7:0] ldata;
   int n_mismatch = 0;
   int checked = 0;
   int rcv = 0;
   // Open-drain pins sit on pull-ups
   wire cck = cck_oe ? cck_o : hclk;
   wire ceo_pin = !(ceo_oe && !ceo_o);
   wire lc_pin = !(lc_oe && !lc_o);
   wire sbit = (mode == 2'h2) ? mem_bit : tb_bit;
   initial forever #50 clk_i = !clk_i;
   ccp_top u_ccp_top (.clk_i(clk_i), .rst_i(rst_i), .config_clock_i(cck),
      .chain_enable_in_n_i(chain_enable_in), .chain_enable_out_n_i(ceo_pin),
      .chain_enable_out_n_o(ceo_o), .chain_enable_out_oe_o(ceo_oe),
      .mode_sel_i(mode), .dual_purpose_user_i(dual),
      .config_clock_o(cck_o), .config_clock_oe_o(cck_oe),
      .serial_cmd_out_o(cmd), .flash_select_n_o(cs_n),
      .serial_config_bit_i(sbit), .parallel_config_byte_i(tb_byte),
      .host_ready_o(hrdy), .load_complete_i(lc_pin),
      .load_complete_o(lc_o), .load_complete_oe_o(lc_oe),
      .user_ceo_out_i(u_out), .user_ceo_oe_i(dual), .user_ceo_in_o(ceo_in),
      .load_data_o(ldata), .load_valid_o(lvalid), .load_ready_i(ready),
      .configured_o(cfgd));
   ccp_mem_model u_ccp_mem_model (.sck_i(cck), .cs_n_i(cs_n),
      .cmd_i(cmd), .dq_o(mem_bit));
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic timeout();
      chk(1'b0, "timeout");
      end_of_test();
   endtask
   always @(negedge clk_i) ready <= !stall;
   always @(posedge clk_i) begin
      if (lvalid === 1'b1 && ready) begin
         chk(ldata === 8'(rcv * 3 + 1), "load byte");
         rcv++;
      end
   end
   // One link clock cycle; the clock stands still between frames
   task automatic pulse();
      #40 hclk = 1'b1;
      #40 hclk = 1'b0;
   endtask
   task automatic start(input logic [1:0] m, input logic d, input logic e);
      rst_i = 1'b1;
      mode = m;
      dual = d;
      chain_enable_in = 1'b1;
      rcv = 0;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      chain_enable_in = e;
      repeat (10) @(negedge clk_i);
      #13;
   endtask
   task automatic host_load(input logic ser);
      int i;
      logic [7:0] v;
      chk(lc_pin === 1'b0, "early complete");
      pulse();
      pulse();
      for (int b = 0; b < int'(ccp_pkg::LOAD_BYTES); b++) begin
         for (i = 0; i < 400 && hrdy !== 1'b1; i++) begin
            stall = 1'b0;
            // The full flag only refreshes on link edges
            if (ser) #80;
            else pulse();
         end
         if (i == 400) timeout();
         v = 8'(b * 3 + 1);
         if (ser) begin
            for (int j = 7; j >= 0; j--) begin
               tb_bit = v[j];
               pulse();
            end
         end else begin
            tb_byte = v;
            pulse();
         end
      end
   endtask
   task automatic finish_load(input logic pin);
      int i;
      for (i = 0; i < 5000 && cfgd !== 1'b1; i++) @(negedge clk_i);
      if (i == 5000) timeout();
      repeat (4) @(negedge clk_i);
      chk(rcv == int'(ccp_pkg::LOAD_BYTES), "byte count");
      chk(ceo_pin === pin, "chain out");
      chk(lc_pin === 1'b1, "load complete");
      chk(cck_o === ccp_pkg::CLOCK_PARK_LEVEL, "clock park");
      repeat (12) pulse();
      chk(rcv == int'(ccp_pkg::LOAD_BYTES) && cfgd === 1'b1, "reload");
   endtask
   task automatic no_enable();
      start(ccp_pkg::MODE_SELF_FETCH, 1'b0, 1'b1);
      repeat (20) pulse();
      repeat (8) @(negedge clk_i);
      chk(rcv == 0 && cfgd === 1'b0 && ceo_pin === 1'b1, "no enable");
      chk(cs_n === 1'b1 && cck_oe === 1'b0, "idle pins");
      chain_enable_in = 1'b0;
      repeat (8) @(negedge clk_i);
      chk(cs_n === 1'b0 && lc_pin === 1'b0, "enable ignored");
      // Raising the enable mid-load abandons the load
      chain_enable_in = 1'b1;
      repeat (8) @(negedge clk_i);
      chk(cs_n === 1'b1 && cck_oe === 1'b0 && rcv == 0, "no abort");
   endtask
   task automatic fetch();
      start(ccp_pkg::MODE_SELF_FETCH, 1'b1, 1'b0);
      repeat (60) @(negedge clk_i);
      chk(cs_n === 1'b0 && cck_oe === 1'b1, "fetch pins");
      finish_load(1'b1);
      chk(u_ccp_mem_model.cmd_q === ccp_pkg::READ_CMD, "read command");
      u_out = 1'b0;
      repeat (4) @(negedge clk_i);
      chk(ceo_pin === 1'b0, "user drive");
      chk(ceo_in === 1'b0, "pin readback");
   endtask
   initial begin
      no_enable();
      start(ccp_pkg::MODE_PASSIVE_SERIAL, 1'b0, 1'b0);
      host_load(1'b1);
      finish_load(1'b0);
      start(ccp_pkg::MODE_PARALLEL_BYTE, 1'b0, 1'b0);
      stall = 1'b1;
      host_load(1'b0);
      chk(stall === 1'b0, "buffer never filled");
      finish_load(1'b0);
      fetch();
      end_of_test();
   end
endmodule // tb_top
bind ccp_top ccp_chk u_ccp_chk (.clk_i, .rst_i, .chain_enable_in_n_i,
   .chain_enable_out_n_o, .chain_enable_out_oe_o, .mode_sel_i,
   .dual_purpose_user_i, .config_clock_o, .config_clock_oe_o,
   .flash_select_n_o, .load_complete_i, .load_complete_o,
   .load_complete_oe_o, .user_ceo_out_i, .user_ceo_oe_i, .configured_o);

/* rtl/ccp_pkg.sv */
// Shared constants and types of the configuration pin controller
package ccp_pkg;

   // Configuration scheme straps
   localparam logic [1:0] MODE_PASSIVE_SERIAL = 2'h0;
   localparam logic [1:0] MODE_PARALLEL_BYTE = 2'h1;
   localparam logic [1:0] MODE_SELF_FETCH = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONFIG,
      ST_INIT,
      ST_USER
   } ccp_state_t;

   // Data path buffer
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   // Margin covers the pointer crossing lag while the fetch clock runs
   localparam logic [4:0] FIFO_STALL_LEVEL = 5'h0C;

   // Load length and initialization length
   localparam logic [15:0] LOAD_BYTES = 16'h0040;
   localparam logic [7:0] INIT_CYCLES = 8'h20;

   // Memory read command: opcode then a zero start address
   localparam logic [31:0] READ_CMD = 32'h0300_0000;
   localparam logic [5:0] CMD_BITS = 6'h20;

   // Self-fetch clock timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int FETCH_CLK_NS = 200;
   localparam logic [3:0] FETCH_HALF_CYCLES =
      4'(FETCH_CLK_NS / (2 * CLK_PERIOD_NS));
   localparam logic CLOCK_PARK_LEVEL = 1'b0;

endpackage : ccp_pkg

/* rtl/ccp_top.sv */
// Configuration pin controller: chain enables, config clock and data capture

// Dual clock FIFO with gray-coded pointers, valid/ready on both sides
module ccp_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Write side
   input wire logic wclk_i,
   input wire logic wrst_i,
   input wire logic wvalid_i,
   output logic wready_o,
   input wire logic [W-1:0] wdata_i,
   // Read side
   input wire logic rclk_i,
   input wire logic rrst_i,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic [W-1:0] rdata_o,
   output logic [$clog2(D):0] rlevel_o
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] rg_s1;
      logic [AW:0] rg_s2;
   } ccp_fifo_w_t;

   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] wg_s1;
      logic [AW:0] wg_s2;
   } ccp_fifo_r_t;

   ccp_fifo_w_t w_ff, nxt_w;
   ccp_fifo_r_t r_ff, nxt_r;
   logic [AW:0] wbin_seen;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [AW:0] from_gray(input logic [AW:0] g);
      logic [AW:0] b;
      b = g;
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // Full when the write pointer is one lap ahead of the read pointer
   assign wready_o = w_ff.gray !=
      {~w_ff.rg_s2[AW:AW-1], w_ff.rg_s2[AW-2:0]};
   assign rvalid_o = r_ff.gray != r_ff.wg_s2;
   assign rdata_o = w_ff.mem[r_ff.bin[AW-1:0]];
   assign wbin_seen = from_gray(r_ff.wg_s2);
   assign rlevel_o = wbin_seen - r_ff.bin;

   always_comb begin
      nxt_w = w_ff;
      nxt_w.rg_s1 = r_ff.gray;
      nxt_w.rg_s2 = w_ff.rg_s1;
      if (wvalid_i && wready_o) begin
         nxt_w.mem[w_ff.bin[AW-1:0]] = wdata_i;
         nxt_w.bin = w_ff.bin + 1'b1;
         nxt_w.gray = to_gray(nxt_w.bin);
      end
   end

   always_comb begin
      nxt_r = r_ff;
      nxt_r.wg_s1 = w_ff.gray;
      nxt_r.wg_s2 = r_ff.wg_s1;
      if (rvalid_o && rready_i) begin
         nxt_r.bin = r_ff.bin + 1'b1;
         nxt_r.gray = to_gray(nxt_r.bin);
      end
   end

   always_ff @(posedge wclk_i or posedge wrst_i) begin
      if (wrst_i) begin
         w_ff <= '0;
      end else begin
         w_ff <= nxt_w;
      end
   end

   always_ff @(posedge rclk_i or posedge rrst_i) begin
      if (rrst_i) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end
endmodule // ccp_fifo

module ccp_top (
   // Clocks and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic config_clock_i,
   // Chain enable pins
   input wire logic chain_enable_in_n_i,
   input wire logic chain_enable_out_n_i,
   output logic chain_enable_out_n_o,
   output logic chain_enable_out_oe_o,
   // Straps
   input wire logic [1:0] mode_sel_i,
   input wire logic dual_purpose_user_i,
   // Configuration clock and memory pins
   output logic config_clock_o,
   output logic config_clock_oe_o,
   output logic serial_cmd_out_o,
   output logic flash_select_n_o,
   // Configuration data pins
   input wire logic serial_config_bit_i,
   input wire logic [7:0] parallel_config_byte_i,
   output logic host_ready_o,
   // Load status pin
   input wire logic load_complete_i,
   output logic load_complete_o,
   output logic load_complete_oe_o,
   // User side
   input wire logic user_ceo_out_i,
   input wire logic user_ceo_oe_i,
   output logic user_ceo_in_o,
   output logic [7:0] load_data_o,
   output logic load_valid_o,
   input wire logic load_ready_i,
   output logic configured_o
);
   typedef struct packed {
      ccp_pkg::ccp_state_t state;
      logic [1:0] mode;
      logic cen_s1;
      logic cen_s2;
      logic [1:0] msel_s1;
      logic [1:0] msel_s2;
      logic dpu_s1;
      logic dpu_s2;
      logic lc_s1;
      logic lc_s2;
      logic ceo_s1;
      logic ceo_s2;
      logic [15:0] bytes;
      logic [7:0] init_cnt;
      logic [3:0] half_cnt;
      logic dclk;
      logic cs_n;
      logic [31:0] cmd_sr;
      logic link_en;
   } ccp_core_t;

   typedef struct packed {
      logic en_s1;
      logic en_s2;
      logic [1:0] md_s1;
      logic [1:0] md_s2;
      logic [5:0] skip;
      logic [2:0] bit_cnt;
      logic [7:0] sh;
   } ccp_link_t;

   ccp_core_t c_ff, nxt_c;
   ccp_link_t l_ff, nxt_l;
   logic wvalid;
   logic [7:0] wdata;
   logic wready;
   logic rvalid;
   logic rready;
   logic [4:0] rlevel;
   logic in_config;
   logic fetching;
   logic take;

   ccp_fifo #(
      .W(ccp_pkg::FIFO_WIDTH),
      .D(ccp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .wclk_i(config_clock_i),
      .wrst_i(rst_i),
      .wvalid_i(wvalid),
      .wready_o(wready),
      .wdata_i(wdata),
      .rclk_i(clk_i),
      .rrst_i(rst_i),
      .rvalid_o(rvalid),
      .rready_i(rready),
      .rdata_o(load_data_o),
      .rlevel_o(rlevel)
   );

   assign in_config = c_ff.state == ccp_pkg::ST_CONFIG;
   assign fetching = in_config && c_ff.mode == ccp_pkg::MODE_SELF_FETCH;
   assign take = in_config && rvalid && load_ready_i;
   // Outside a load, stray bytes are drained so the load stays unchanged
   assign rready = !in_config || load_ready_i;
   assign load_valid_o = in_config && rvalid;
   assign host_ready_o = wready;
   assign configured_o = c_ff.state == ccp_pkg::ST_USER;

   // Core state on the system clock
   always_comb begin
      nxt_c = c_ff;
      nxt_c.cen_s1 = chain_enable_in_n_i;
      nxt_c.cen_s2 = c_ff.cen_s1;
      nxt_c.msel_s1 = mode_sel_i;
      nxt_c.msel_s2 = c_ff.msel_s1;
      nxt_c.dpu_s1 = dual_purpose_user_i;
      nxt_c.dpu_s2 = c_ff.dpu_s1;
      nxt_c.lc_s1 = load_complete_i;
      nxt_c.lc_s2 = c_ff.lc_s1;
      nxt_c.ceo_s1 = chain_enable_out_n_i;
      nxt_c.ceo_s2 = c_ff.ceo_s1;
      case (c_ff.state)
         ccp_pkg::ST_IDLE: begin
            // Mode loads on the same edge as the link enable rises, so the link
            // never pairs a new enable with a stale mode
            nxt_c.mode = c_ff.msel_s2;
            if (!c_ff.cen_s2) begin
               nxt_c.state = ccp_pkg::ST_CONFIG;
               nxt_c.bytes = '0;
               nxt_c.half_cnt = '0;
               nxt_c.cmd_sr = ccp_pkg::READ_CMD;
            end
         end
         ccp_pkg::ST_CONFIG: begin
            if (c_ff.cen_s2) begin
               nxt_c.state = ccp_pkg::ST_IDLE;
            end else if (take) begin
               nxt_c.bytes = c_ff.bytes + 16'h0001;
               if (c_ff.bytes == ccp_pkg::LOAD_BYTES - 16'h0001) begin
                  nxt_c.state = ccp_pkg::ST_INIT;
                  nxt_c.init_cnt = '0;
               end
            end
         end
         ccp_pkg::ST_INIT: begin
            if (c_ff.init_cnt != ccp_pkg::INIT_CYCLES) begin
               nxt_c.init_cnt = c_ff.init_cnt + 8'h01;
            end else if (c_ff.lc_s2) begin
               // Waits for the released status line to read high
               nxt_c.state = ccp_pkg::ST_USER;
            end
         end
         ccp_pkg::ST_USER: begin
            nxt_c.state = ccp_pkg::ST_USER;
         end
         default: begin
            nxt_c.state = ccp_pkg::ST_IDLE;
         end
      endcase
      // Fetch clock pauses while the buffer is near full
      nxt_c.dclk = ccp_pkg::CLOCK_PARK_LEVEL;
      // Select leads the first clock rise by one system clock cycle, half a fetch clock period
      if (fetching && !c_ff.cs_n && nxt_c.state == ccp_pkg::ST_CONFIG) begin
         nxt_c.dclk = c_ff.dclk;
         if (rlevel < ccp_pkg::FIFO_STALL_LEVEL) begin
            if (c_ff.half_cnt == ccp_pkg::FETCH_HALF_CYCLES - 4'h1) begin
               nxt_c.half_cnt = '0;
               nxt_c.dclk = !c_ff.dclk;
               if (c_ff.dclk) begin
                  // Memory samples the command on the rising edge
                  nxt_c.cmd_sr = {c_ff.cmd_sr[30:0], 1'b0};
               end
            end else begin
               nxt_c.half_cnt = c_ff.half_cnt + 4'h1;
            end
         end
      end
      nxt_c.cs_n = !(fetching && nxt_c.state == ccp_pkg::ST_CONFIG);
      nxt_c.link_en = nxt_c.state == ccp_pkg::ST_CONFIG;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         c_ff <= '{state: ccp_pkg::ST_IDLE, cen_s1: 1'b1, cen_s2: 1'b1,
                   cs_n: 1'b1, dclk: ccp_pkg::CLOCK_PARK_LEVEL,
                   default: '0};
      end else begin
         c_ff <= nxt_c;
      end
   end

   // Link capture on the configuration clock pin
   always_comb begin
      nxt_l = l_ff;
      nxt_l.en_s1 = c_ff.link_en;
      nxt_l.en_s2 = l_ff.en_s1;
      nxt_l.md_s1 = c_ff.mode;
      nxt_l.md_s2 = l_ff.md_s1;
      wvalid = 1'b0;
      wdata = {l_ff.sh[6:0], serial_config_bit_i};
      if (!l_ff.en_s2) begin
         // Once disabled, further clock edges load nothing
         nxt_l.skip = '0;
         nxt_l.bit_cnt = '0;
      end else if (l_ff.md_s2 == ccp_pkg::MODE_PARALLEL_BYTE) begin
         wvalid = 1'b1;
         wdata = parallel_config_byte_i;
      end else if (l_ff.md_s2 == ccp_pkg::MODE_SELF_FETCH &&
                   l_ff.skip != ccp_pkg::CMD_BITS - 6'h02) begin
         // Edges spent on the read command carry no data; the two
         // enable synchroniser edges are already part of the command
         nxt_l.skip = l_ff.skip + 6'h01;
      end else begin
         nxt_l.sh = wdata;
         nxt_l.bit_cnt = l_ff.bit_cnt + 3'h1;
         wvalid = l_ff.bit_cnt == 3'h7;
      end
   end

   // Link flops release without a clock since the pin clock may be idle
   always_ff @(posedge config_clock_i or posedge rst_i) begin
      if (rst_i) begin
         l_ff <= '0;
      end else begin
         l_ff <= nxt_l;
      end
   end

   // Pin drive
   always_comb begin
      config_clock_o = c_ff.dclk;
      config_clock_oe_o = c_ff.mode == ccp_pkg::MODE_SELF_FETCH &&
         c_ff.state != ccp_pkg::ST_IDLE;
      serial_cmd_out_o = c_ff.cmd_sr[31];
      flash_select_n_o = c_ff.cs_n;
      load_complete_o = 1'b0;
      load_complete_oe_o = c_ff.state == ccp_pkg::ST_IDLE ||
         c_ff.state == ccp_pkg::ST_CONFIG;
      user_ceo_in_o = c_ff.ceo_s2;
      chain_enable_out_n_o = 1'b0;
      chain_enable_out_oe_o = 1'b0;
      if (c_ff.state == ccp_pkg::ST_USER) begin
         if (c_ff.dpu_s2) begin
            chain_enable_out_n_o = user_ceo_out_i;
            chain_enable_out_oe_o = user_ceo_oe_i;
         end else begin
            chain_enable_out_oe_o = 1'b1;
         end
      end
   end
endmodule // ccp_top
